// ---- dcc_params.svh ----
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCC_OFS_PRIMARY 12'h000
`define DCC_OFS_LINK 12'h004
`define DCC_OFS_FWD_ADDR 12'h008
`define DCC_OFS_REV_ADDR 12'h00C
`define DCC_OFS_TIMEOUT 12'h010
`define DCC_OFS_FAULT 12'h014
`define DCC_OFS_UNLOCK 12'h018
`define DCC_OFS_DBG_A 12'h01C
`define DCC_OFS_DBG_B 12'h020
`define DCC_OFS_DBG_STAT 12'h024

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCC_PC_ASSIGN 0
`define DCC_PC_DIR 1
`define DCC_LC_STACK 0
`define DCC_LC_END 1
`define DCC_TC_SHORT_LSB 0
`define DCC_TC_SHORT_EN 3
`define DCC_TC_LONG_LSB 4
`define DCC_TC_LONG_ACT 7
`define DCC_TC_LONG_EN 8
`define DCC_FS_SHORT 0
`define DCC_FS_LONG 1
`define DCC_DA_CHAIN 0
`define DCC_DA_SERIAL 1
`define DCC_DA_MIRROR 2
`define DCC_DA_STX 3
`define DCC_DA_SLOW 4
`define DCC_DB_UTX 0
`define DCC_DB_URX 1
`define DCC_DB_LTX 2
`define DCC_DB_LRX 3

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define DCC_RST_PRIMARY 2'h0
`define DCC_RST_LINK 2'h0
`define DCC_RST_ADDR 6'h00
`define DCC_RST_TIMEOUT 9'h000
`define DCC_RST_UNLOCK 8'h00
`define DCC_RST_DBG_A 5'h00
`define DCC_RST_DBG_B 4'h0
`define DCC_UNLOCK_CODE 8'hA5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCC_CLK_MHZ 250
`define DCC_NORMAL_KBPS 1000
`define DCC_SLOW_KBPS 250
`define DCC_SHORT_UNIT_US 100000
`define DCC_LONG_UNIT_US 1000000

`endif

// ---- dcc_pkg.sv ----
package dcc_pkg;

	// power mode reported by the power controller
	typedef enum logic [1:0] {
		DCC_PM_ACTIVE = 2'h0,
		DCC_PM_SLEEP = 2'h1,
		DCC_PM_SHUTDOWN = 2'h2
	} dcc_power_t;

	// address-assign frame tracking
	typedef enum logic [1:0] {
		DCC_AA_IDLE = 2'h0,
		DCC_AA_WAIT = 2'h1,
		DCC_AA_HOLD = 2'h2
	} dcc_assign_t;

endpackage

// ---- dcc_link_ctrl.sv ----
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "dcc_params.svh"

// Operation
// - direction selects active address, registered one edge later
// - port roles follow direction and chain end
// - base direction one: upper off, lower on
// - reversed chain end disables lower transmitter
// - only valid frames restart timeout timers
// - timers count active, clear shutdown, freeze sleep
// - short timeout period field, sets alert flag
// - long timeout: fault and sleep, or shutdown
// - unlock code enables debug controls, else normal
// - chain override drives port enables directly
// - serial override mirrors chain traffic to serial
// - slow rate only under serial override
// - assign mode suppresses one frame, clears bit
// - chain end disables upward transmitter
module dcc_link_ctrl #(
	parameter int ADDR_W = 12,
	parameter logic [31:0] SHORT_UNIT_CYC =
		32'(`DCC_SHORT_UNIT_US * `DCC_CLK_MHZ),
	parameter logic [31:0] LONG_UNIT_CYC =
		32'(`DCC_LONG_UNIT_US * `DCC_CLK_MHZ)
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic baseUnit,
	input wire logic [1:0] powerMode,
	input wire logic frameValid,
	input wire logic chainFrameStart,
	input wire logic chainFrameEnd,
	output logic upperTxEn,
	output logic upperRxEn,
	output logic lowerTxEn,
	output logic lowerRxEn,
	output logic serialTxEn,
	output logic mirrorEn,
	output logic [9:0] serialBitCycles,
	output logic [5:0] unitAddress,
	output logic sleepReq,
	output logic shutdownReq
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// period of a timeout code: (code + 1) units
	function automatic logic [31:0] periodCycles(
		input logic [2:0] code,
		input logic [31:0] unit
	);
		logic [31:0] n;
		n = {29'h0000_0000, code} + 32'h0000_0001;
		periodCycles = n * unit;
	endfunction

	// next timer value; stops at the period so expiry fires once
	function automatic logic [31:0] timerNext(
		input logic [31:0] cnt,
		input logic [31:0] period,
		input logic enable,
		input logic [1:0] mode,
		input logic restart
	);
		if (mode == dcc_pkg::DCC_PM_SHUTDOWN || !enable) begin
			timerNext = 32'h0000_0000;
		end else if (mode != dcc_pkg::DCC_PM_ACTIVE) begin
			timerNext = cnt;
		end else if (restart) begin
			timerNext = 32'h0000_0000;
		end else if (cnt >= period) begin
			timerNext = cnt;
		end else begin
			timerNext = cnt + 32'h0000_0001;
		end
	endfunction

	localparam logic [9:0] NORMAL_BIT_CYC =
		10'(`DCC_CLK_MHZ * 1000 / `DCC_NORMAL_KBPS);
	localparam logic [9:0] SLOW_BIT_CYC =
		10'(`DCC_CLK_MHZ * 1000 / `DCC_SLOW_KBPS);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [1:0] primary_reg;
	logic [1:0] link_reg;
	logic [5:0] fwdAddr_reg;
	logic [5:0] revAddr_reg;
	logic [8:0] timeout_reg;
	logic [1:0] fault_reg;
	logic [7:0] unlock_reg;
	logic [4:0] dbgA_reg;
	logic [3:0] dbgB_reg;
	logic [31:0] shortCnt_reg;
	logic [31:0] longCnt_reg;
	dcc_pkg::dcc_assign_t assign_reg;
	dcc_pkg::dcc_assign_t assign_next;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------

	// one wait state: pready rises in the second access cycle
	wire access = psel & penable & pready;
	wire wrEn = access & pwrite;
	wire selPrimary = paddr == ADDR_W'(`DCC_OFS_PRIMARY);
	wire selLink = paddr == ADDR_W'(`DCC_OFS_LINK);
	wire selFwd = paddr == ADDR_W'(`DCC_OFS_FWD_ADDR);
	wire selRev = paddr == ADDR_W'(`DCC_OFS_REV_ADDR);
	wire selTimeout = paddr == ADDR_W'(`DCC_OFS_TIMEOUT);
	wire selFault = paddr == ADDR_W'(`DCC_OFS_FAULT);
	wire selUnlock = paddr == ADDR_W'(`DCC_OFS_UNLOCK);
	wire selDbgA = paddr == ADDR_W'(`DCC_OFS_DBG_A);
	wire selDbgB = paddr == ADDR_W'(`DCC_OFS_DBG_B);
	wire selStat = paddr == ADDR_W'(`DCC_OFS_DBG_STAT);
	wire hit = selPrimary | selLink | selFwd | selRev | selTimeout |
		selFault | selUnlock | selDbgA | selDbgB | selStat;

	// ------------------------------------------------------------
	// field views
	// ------------------------------------------------------------
	wire assignBit = primary_reg[`DCC_PC_ASSIGN];
	wire dirSel = primary_reg[`DCC_PC_DIR];
	wire chainEnd = link_reg[`DCC_LC_END];
	wire debugOn = unlock_reg == `DCC_UNLOCK_CODE;
	wire chainUser = debugOn & dbgA_reg[`DCC_DA_CHAIN];
	wire serialUser = debugOn & dbgA_reg[`DCC_DA_SERIAL];
	wire [31:0] shortPeriod =
		periodCycles(timeout_reg[`DCC_TC_SHORT_LSB +: 3], SHORT_UNIT_CYC);
	wire [31:0] longPeriod =
		periodCycles(timeout_reg[`DCC_TC_LONG_LSB +: 3], LONG_UNIT_CYC);
	wire shortOn = timeout_reg[`DCC_TC_SHORT_EN];
	wire longOn = timeout_reg[`DCC_TC_LONG_EN];
	wire longAct = timeout_reg[`DCC_TC_LONG_ACT];
	wire isActive = powerMode == dcc_pkg::DCC_PM_ACTIVE;

	// ------------------------------------------------------------
	// address-assign tracking
	// ------------------------------------------------------------

	// the frame after arming is the unit's own address write; it must
	// not travel on, so the upward transmitter is held off until it ends
	always_comb begin
		assign_next = assign_reg;
		case (assign_reg)
			dcc_pkg::DCC_AA_IDLE: begin
				if (assignBit) begin
					assign_next = dcc_pkg::DCC_AA_WAIT;
				end
			end
			dcc_pkg::DCC_AA_WAIT: begin
				if (!assignBit) begin
					assign_next = dcc_pkg::DCC_AA_IDLE;
				end else if (chainFrameStart) begin
					assign_next = dcc_pkg::DCC_AA_HOLD;
				end
			end
			dcc_pkg::DCC_AA_HOLD: begin
				if (chainFrameEnd) begin
					assign_next = dcc_pkg::DCC_AA_IDLE;
				end
			end
			default: begin
				assign_next = dcc_pkg::DCC_AA_IDLE;
			end
		endcase
	end

	wire suppress = assign_next == dcc_pkg::DCC_AA_HOLD;
	wire assignDone = assign_reg == dcc_pkg::DCC_AA_HOLD & chainFrameEnd;

	// a software set in the same cycle beats the hardware clear
	wire assignSet = wrEn & selPrimary & pwdata[`DCC_PC_ASSIGN];
	wire [1:0] primary_next = wrEn & selPrimary ?
		{pwdata[`DCC_PC_DIR], assignSet | (assignBit & ~assignDone)} :
		{dirSel, assignBit & ~assignDone};

	// ------------------------------------------------------------
	// communication timeouts
	// ------------------------------------------------------------
	wire [31:0] shortCnt_next = timerNext(shortCnt_reg, shortPeriod,
		shortOn, powerMode, frameValid);
	wire [31:0] longCnt_next = timerNext(longCnt_reg, longPeriod,
		longOn, powerMode, frameValid);
	wire shortFire = isActive & shortOn & ~frameValid &
		shortCnt_reg == shortPeriod - 32'h0000_0001;
	wire longFire = isActive & longOn & ~frameValid &
		longCnt_reg == longPeriod - 32'h0000_0001;

	// sticky flags: set wins over a write-one clear
	wire [1:0] faultSet = {longFire & ~longAct, shortFire};
	wire [1:0] faultClr = wrEn & selFault ? pwdata[1:0] : 2'h0;
	wire [1:0] fault_next = faultSet | (fault_reg & ~faultClr);

	// ------------------------------------------------------------
	// chain port roles
	// ------------------------------------------------------------

	// upward port is the one frames from the host leave by
	wire upIsUpper = ~dirSel;
	wire upOff = chainEnd | suppress;
	wire nUpperOn = baseUnit ? ~dirSel : 1'b1;
	wire nLowerOn = baseUnit ? dirSel : 1'b1;
	wire nUpperTx = nUpperOn & ~(upIsUpper & upOff);
	wire nLowerTx = nLowerOn & ~(~upIsUpper & upOff);
	wire upperTx_next = chainUser ? dbgB_reg[`DCC_DB_UTX] : nUpperTx;
	wire upperRx_next = chainUser ? dbgB_reg[`DCC_DB_URX] : nUpperOn;
	wire lowerTx_next = chainUser ? dbgB_reg[`DCC_DB_LTX] : nLowerTx;
	wire lowerRx_next = chainUser ? dbgB_reg[`DCC_DB_LRX] : nLowerOn;

	// serial port: stacked units keep transmit off unless overridden
	wire serialTx_next = baseUnit |
		(serialUser & dbgA_reg[`DCC_DA_STX]);
	wire mirror_next = serialUser & dbgA_reg[`DCC_DA_MIRROR];
	wire [9:0] bitCyc_next = serialUser & dbgA_reg[`DCC_DA_SLOW] ?
		SLOW_BIT_CYC : NORMAL_BIT_CYC;

	// the address in use follows direction one edge later, through its own register
	wire [5:0] addr_next = dirSel ? revAddr_reg : fwdAddr_reg;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	wire [6:0] statBits = {serialTxEn, lowerRxEn, lowerTxEn,
		upperRxEn, upperTxEn, serialUser, chainUser};
	wire [31:0] rdMux =
		selPrimary ? {30'h0000_0000, primary_reg} :
		selLink ? {30'h0000_0000, link_reg} :
		selFwd ? {26'h000_0000, fwdAddr_reg} :
		selRev ? {26'h000_0000, revAddr_reg} :
		selTimeout ? {23'h00_0000, timeout_reg} :
		selFault ? {30'h0000_0000, fault_reg} :
		selUnlock ? {24'h00_0000, unlock_reg} :
		selDbgA ? {27'h000_0000, dbgA_reg} :
		selDbgB ? {28'h000_0000, dbgB_reg} :
		selStat ? {25'h000_0000, statBits} :
		32'h0000_0000;

	// ------------------------------------------------------------
	// apb handshake
	// ------------------------------------------------------------

	// read data is captured one edge before pready is sampled
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clkEn) begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			if (psel & penable & ~pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rdMux;
			end
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------

	// writes land only at the edge where pready is sampled high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			primary_reg <= `DCC_RST_PRIMARY;
			link_reg <= `DCC_RST_LINK;
			fwdAddr_reg <= `DCC_RST_ADDR;
			revAddr_reg <= `DCC_RST_ADDR;
			timeout_reg <= `DCC_RST_TIMEOUT;
			unlock_reg <= `DCC_RST_UNLOCK;
			dbgA_reg <= `DCC_RST_DBG_A;
			dbgB_reg <= `DCC_RST_DBG_B;
		end else if (clkEn) begin
			primary_reg <= primary_next;
			if (wrEn & selLink) link_reg <= pwdata[1:0];
			if (wrEn & selFwd) fwdAddr_reg <= pwdata[5:0];
			if (wrEn & selRev) revAddr_reg <= pwdata[5:0];
			if (wrEn & selTimeout) timeout_reg <= pwdata[8:0];
			if (wrEn & selUnlock) unlock_reg <= pwdata[7:0];
			if (wrEn & selDbgA) dbgA_reg <= pwdata[4:0];
			if (wrEn & selDbgB) dbgB_reg <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// timers, flags and assign state
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			shortCnt_reg <= 32'h0000_0000;
			longCnt_reg <= 32'h0000_0000;
			fault_reg <= 2'h0;
			assign_reg <= dcc_pkg::DCC_AA_IDLE;
			sleepReq <= 1'b0;
			shutdownReq <= 1'b0;
		end else if (clkEn) begin
			shortCnt_reg <= shortCnt_next;
			longCnt_reg <= longCnt_next;
			fault_reg <= fault_next;
			assign_reg <= assign_next;
			sleepReq <= longFire & ~longAct;
			shutdownReq <= longFire & longAct;
		end
	end

	// ------------------------------------------------------------
	// port enables and serial controls
	// ------------------------------------------------------------

	// all outputs registered; a setting change shows one edge later
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			upperTxEn <= 1'b0;
			upperRxEn <= 1'b0;
			lowerTxEn <= 1'b0;
			lowerRxEn <= 1'b0;
			serialTxEn <= 1'b0;
			mirrorEn <= 1'b0;
			serialBitCycles <= NORMAL_BIT_CYC;
			unitAddress <= `DCC_RST_ADDR;
		end else if (clkEn) begin
			upperTxEn <= upperTx_next;
			upperRxEn <= upperRx_next;
			lowerTxEn <= lowerTx_next;
			lowerRxEn <= lowerRx_next;
			serialTxEn <= serialTx_next;
			mirrorEn <= mirror_next;
			serialBitCycles <= bitCyc_next;
			unitAddress <= addr_next;
		end
	end

endmodule

// ---- dcc_link_ctrl_checker.sv ----
`timescale 1ns/1ns
// ----------
// link control checks
// ----------
module dcc_link_ctrl_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic baseUnit,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] powerMode,
	input wire logic chainFrameStart,
	input wire logic chainFrameEnd,
	input wire logic upperTxEn,
	input wire logic upperRxEn,
	input wire logic lowerTxEn,
	input wire logic lowerRxEn,
	input wire logic [9:0] serialBitCycles,
	input wire logic [5:0] unitAddress,
	input wire logic sleepReq,
	input wire logic shutdownReq
);
	logic wrDone;
	logic evNow;
	logic anyReq;
	logic [2:0] evHist_reg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// causes that may move the port enables
	assign wrDone = psel && penable && pready && pwrite;
	assign evNow = wrDone || chainFrameStart || chainFrameEnd;
	assign anyReq = sleepReq || shutdownReq;
	// reset fills the history so the first computed enables pass
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			evHist_reg <= 3'h7;
		else
			evHist_reg <= {evHist_reg[1:0], evNow};
	end
	chk_apb_wait: assert property (
		$rose(penable) && psel && clkEn |-> !pready ##1 pready)
		else $error("apb wait state wrong");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_addr_follow: assert property (
		$changed(unitAddress) |-> $past(wrDone, 2))
		else $error("address moved without a write");
	chk_port_cause: assert property (
		$changed({upperTxEn, upperRxEn, lowerTxEn, lowerRxEn}) |->
		|evHist_reg || $past(baseUnit, 2) != baseUnit)
		else $error("port enables moved without cause");
	chk_rate_pair: assert property (
		serialBitCycles == 10'h0FA || serialBitCycles == 10'h3E8)
		else $error("serial rate not 1 Mbps or 250 kbps");
	chk_req_pulse: assert property (anyReq |=> !anyReq)
		else $error("power request longer than one cycle");
	chk_req_excl: assert property (!(sleepReq && shutdownReq))
		else $error("sleep and shutdown together");
	chk_frozen_idle: assert property (
		(powerMode != dcc_pkg::DCC_PM_ACTIVE) [*3] |-> !anyReq)
		else $error("timer fired outside active mode");
	cover property (sleepReq);
	cover property (shutdownReq);
	cover property (pslverr);
endmodule

bind dcc_link_ctrl dcc_link_ctrl_checker chk_i (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.clkEn(clkEn),
	.baseUnit(baseUnit),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.pslverr(pslverr),
	.powerMode(powerMode),
	.chainFrameStart(chainFrameStart),
	.chainFrameEnd(chainFrameEnd),
	.upperTxEn(upperTxEn),
	.upperRxEn(upperRxEn),
	.lowerTxEn(lowerTxEn),
	.lowerRxEn(lowerRxEn),
	.serialBitCycles(serialBitCycles),
	.unitAddress(unitAddress),
	.sleepReq(sleepReq),
	.shutdownReq(shutdownReq)
);

// ---- dcc_frame_src.sv ----
`timescale 1ns/1ns
// ----------
// host and neighbour frame source
// ----------
module dcc_frame_src (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic go,
	input wire logic slow,
	input wire logic good,
	output logic frameValid,
	output logic chainFrameStart,
	output logic chainFrameEnd,
	output logic busy
);
	logic [3:0] left_reg;
	// one frame per request; a slow one holds the line longer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			left_reg <= 4'h0;
			chainFrameStart <= 1'b0;
			chainFrameEnd <= 1'b0;
			frameValid <= 1'b0;
		end else begin
			chainFrameStart <= go && !busy;
			chainFrameEnd <= busy && left_reg == 4'h0;
			frameValid <= busy && left_reg == 4'h0 && good;
			if (go && !busy) begin
				busy <= 1'b1;
				left_reg <= slow ? 4'hC : 4'h2;
			end else if (busy) begin
				busy <= left_reg != 4'h0;
				left_reg <= left_reg - 4'h1;
			end
		end
	end
endmodule

// ---- daisy_chain_comm_control_tb_top.sv ----
`timescale 1ns/1ns
`include "dcc_params.svh"
// ----------
// link control bench
// ----------
module daisy_chain_comm_control_tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic baseUnit = 1'b1;
	logic [1:0] powerMode = dcc_pkg::DCC_PM_ACTIVE;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic good = 1'b1;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, busy, seenSleep, seenShut, mirrorEn;
	logic frameValid, chainFrameStart, chainFrameEnd, serialTxEn;
	logic upperTxEn, upperRxEn, lowerTxEn, lowerRxEn, sleepReq, shutdownReq;
	logic [9:0] serialBitCycles;
	logic [5:0] unitAddress;
	logic [3:0] portEn;
	int badCount = 0;
	int compares = 0;
	// short units keep timer runs brief
	assign portEn = {upperTxEn, upperRxEn, lowerTxEn, lowerRxEn};
	dcc_link_ctrl #(.SHORT_UNIT_CYC(32'h0000_0004),
		.LONG_UNIT_CYC(32'h0000_0008)) dut (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.baseUnit(baseUnit),
		.powerMode(powerMode),
		.frameValid(frameValid),
		.chainFrameStart(chainFrameStart),
		.chainFrameEnd(chainFrameEnd),
		.upperTxEn(upperTxEn),
		.upperRxEn(upperRxEn),
		.lowerTxEn(lowerTxEn),
		.lowerRxEn(lowerRxEn),
		.serialTxEn(serialTxEn),
		.mirrorEn(mirrorEn),
		.serialBitCycles(serialBitCycles),
		.unitAddress(unitAddress),
		.sleepReq(sleepReq),
		.shutdownReq(shutdownReq)
	);
	dcc_frame_src src (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.go(go),
		.slow(slow),
		.good(good),
		.frameValid(frameValid),
		.chainFrameStart(chainFrameStart),
		.chainFrameEnd(chainFrameEnd),
		.busy(busy)
	);
	always #2 sys_clk = ~sys_clk;
	// ----------
	// shared tasks
	// ----------
	task chk(input logic [31:0] s, input logic [31:0] e, input string m);
		compares++;
		if (s !== e) begin
			badCount++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task endOfTest;
		$display("mismatches %0d compares %0d", badCount, compares);
		if (badCount == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// held until pready is seen, then released with one idle edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			chk(0, 1, "apb hang");
			endOfTest;
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		tick(2);
	endtask
	task rdChk(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask
	task startFrame(input logic g, input logic s);
		good <= g;
		slow <= s;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask
	task frame(input logic g);
		int n;
		startFrame(g, 1'b0);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (busy !== 1'b0 && n < 30);
		if (busy !== 1'b0) begin
			chk(0, 1, "frame hang");
			endOfTest;
		end
	endtask
	task watch(input int lim);
		seenSleep = 1'b0;
		seenShut = 1'b0;
		for (int n = 0; n < lim && !(seenSleep || seenShut); n++) begin
			@(posedge sys_clk);
			seenSleep = sleepReq;
			seenShut = shutdownReq;
		end
	endtask
	// ----------
	// scenarios
	// ----------
	task tReset;
		frame(1'b1);
		frame(1'b0);
		for (logic [11:0] a = 12'h000; a <= 12'h020; a += 12'h004)
			rdChk(a, 32'h0000_0000, "reset value");
		rdChk(12'h028, 32'h0000_0000, "unmapped data");
		chk(err, 1'b1, "unmapped error");
		wr(`DCC_OFS_DBG_STAT, 32'h0000_007F);
		rdChk(`DCC_OFS_DBG_STAT, 32'h0000_004C, "status");
		chk(portEn, 4'hC, "base ports");
		chk(serialBitCycles, 10'h0FA, "normal rate");
	endtask
	task tDir;
		wr(`DCC_OFS_FWD_ADDR, 32'h0000_0005);
		wr(`DCC_OFS_REV_ADDR, 32'h0000_0009);
		chk(unitAddress, 6'h05, "forward address");
		wr(`DCC_OFS_PRIMARY, 32'h0000_0002);
		chk(unitAddress, 6'h09, "reverse address");
		chk(portEn, 4'h3, "base reversed");
		wr(`DCC_OFS_LINK, 32'h0000_0002);
		chk(portEn, 4'h1, "reversed end");
		wr(`DCC_OFS_PRIMARY, 32'h0000_0000);
		chk(portEn, 4'h4, "forward end");
		wr(`DCC_OFS_LINK, 32'h0000_0000);
	endtask
	task tAssign;
		wr(`DCC_OFS_PRIMARY, 32'h0000_0001);
		startFrame(1'b1, 1'b1);
		tick(3);
		chk(upperTxEn, 1'b0, "own frame kept");
		wr(`DCC_OFS_FWD_ADDR, 32'h0000_0003);
		frame(1'b1);
		tick(1);
		chk(upperTxEn, 1'b1, "forwarding back");
		rdChk(`DCC_OFS_PRIMARY, 32'h0000_0000, "mode cleared");
		chk(unitAddress, 6'h03, "captured");
		startFrame(1'b1, 1'b1);
		tick(3);
		chk(upperTxEn, 1'b1, "next frame passed");
		frame(1'b1);
	endtask
	task tTimeout;
		wr(`DCC_OFS_TIMEOUT, 32'h0000_011B);
		repeat (6) frame(1'b1);
		rdChk(`DCC_OFS_FAULT, 32'h0000_0000, "restarted");
		frame(1'b0);
		watch(12);
		chk({seenSleep, seenShut}, 2'b10, "long sleep");
		tick(2);
		rdChk(`DCC_OFS_FAULT, 32'h0000_0003, "both flags");
		wr(`DCC_OFS_FAULT, 32'h0000_0003);
		frame(1'b1);
		// sleep mid-count, so a cleared counter would fire too late
		tick(8);
		powerMode <= dcc_pkg::DCC_PM_SLEEP;
		watch(40);
		chk({seenSleep, seenShut}, 2'b00, "frozen");
		powerMode <= dcc_pkg::DCC_PM_ACTIVE;
		watch(12);
		chk({seenSleep, seenShut}, 2'b10, "resumed");
		wr(`DCC_OFS_TIMEOUT, 32'h0000_019B);
		frame(1'b1);
		watch(40);
		chk({seenSleep, seenShut}, 2'b01, "long shutdown");
		wr(`DCC_OFS_TIMEOUT, 32'h0000_0000);
		powerMode <= dcc_pkg::DCC_PM_SLEEP;
		tick(4);
		powerMode <= dcc_pkg::DCC_PM_ACTIVE;
		frame(1'b1);
		chk(unitAddress, 6'h03, "address kept");
	endtask
	task tDebug;
		wr(`DCC_OFS_DBG_B, 32'h0000_000A);
		wr(`DCC_OFS_DBG_A, 32'h0000_0017);
		chk({portEn, mirrorEn}, 5'h18, "locked");
		wr(`DCC_OFS_UNLOCK, 32'h0000_00A5);
		chk({portEn, mirrorEn}, 5'h0B, "override");
		chk(serialBitCycles, 10'h3E8, "slow rate");
		rdChk(`DCC_OFS_DBG_STAT, 32'h0000_006B, "status");
		wr(`DCC_OFS_DBG_A, 32'h0000_0011);
		chk(serialBitCycles, 10'h0FA, "no serial user");
		chk(mirrorEn, 1'b0, "no mirror");
		wr(`DCC_OFS_UNLOCK, 32'h0000_0000);
		chk(portEn, 4'hC, "normal again");
		// stacked unit: all ports on, serial tx only by override
		baseUnit <= 1'b0;
		wr(`DCC_OFS_DBG_A, 32'h0000_000A);
		chk({portEn, serialTxEn}, 5'h1E, "stacked ports");
		wr(`DCC_OFS_UNLOCK, 32'h0000_00A5);
		chk(serialTxEn, 1'b1, "stacked serial tx");
	endtask
	// main sequence
	initial begin
		tick(10);
		reset_n <= 1'b1;
		tick(1);
		tReset;
		tDir;
		tAssign;
		tTimeout;
		tDebug;
		endOfTest;
	end
endmodule
